// *** test/bmf_fifo_dev_model.sv ***
// Behavioural model of the clocked bus-matching FIFO device.
`timescale 1ns/1ns
`default_nettype none
module bmf_fifo_dev_model (
   input wire logic port_a_clock_o, port_b_clock_o, port_a_transfer_gate_o, port_b_transfer_gate_o,
   input wire logic port_a_direction_o, port_b_direction_o, port_a_mailbox_select_o, port_b_mailbox_select_o,
   input wire logic master_reset_one_n_o, master_reset_two_n_o, partial_flush_reset_n_o, port_a_data_oe_o,
   input wire logic offset_sel1_serial_load_gate_o, offset_sel0_serial_bit_in_o, serial_program_select_n_o,
   input wire logic port_b_data_oe_o,
   input wire logic [35:0] port_a_data_o, port_b_data_o,
   output logic [35:0] port_a_data_i, port_b_data_i,
   output logic full_or_input_ready_flag_i, empty_or_output_ready_flag_i,
   output logic mail_one_full_flag_n_i = 1'b1, mail_two_full_flag_n_i = 1'b1,
   output logic [19:0] offset_o = '0
);
   logic [35:0] mail1 = '0, mail2 = '0, out_b = '0, q[$];
   logic spm_n = 1'b1;
   int n = 0;
   wire flush = !partial_flush_reset_n_o || !(master_reset_one_n_o || master_reset_two_n_o);
   assign full_or_input_ready_flag_i = n < 1024;
   assign empty_or_output_ready_flag_i = n > 0;
   // bus drive levels; a released bus in write direction shows the inverse.
   assign port_a_data_i = port_a_data_oe_o ? port_a_data_o : port_a_direction_o ? ~mail2 : mail2;
   assign port_b_data_i = port_b_data_oe_o ? port_b_data_o : !port_b_direction_o ? ~out_b :
                          port_b_mailbox_select_o ? mail1 : out_b;
   always @(posedge master_reset_one_n_o) spm_n <= serial_program_select_n_o;
   always @(posedge port_a_clock_o) begin
      if (flush) begin q.delete(); n = 0; end
      if (!partial_flush_reset_n_o || !master_reset_one_n_o) mail_one_full_flag_n_i <= 1'b1;
      else if (!spm_n && !offset_sel1_serial_load_gate_o) offset_o <= {offset_o[18:0], offset_sel0_serial_bit_in_o};
      if (port_a_transfer_gate_o && port_a_direction_o) begin
         if (!port_a_mailbox_select_o) begin q.push_back(port_a_data_o); n++; end
         else if (mail_one_full_flag_n_i) begin mail1 <= port_a_data_o; mail_one_full_flag_n_i <= 1'b0; end
      end else if (port_a_transfer_gate_o && port_a_mailbox_select_o) mail_two_full_flag_n_i <= 1'b1;
   end
   always @(posedge port_b_clock_o) begin
      if (flush) out_b <= '0;
      if (!partial_flush_reset_n_o || !master_reset_two_n_o) mail_two_full_flag_n_i <= 1'b1;
      if (port_b_transfer_gate_o && !port_b_direction_o) begin
         if (port_b_mailbox_select_o && mail_two_full_flag_n_i) begin mail2 <= port_b_data_o; mail_two_full_flag_n_i <= 1'b0; end
      end else if (port_b_transfer_gate_o && port_b_mailbox_select_o) mail_one_full_flag_n_i <= 1'b1;
      else if (port_b_transfer_gate_o && n > 0) begin out_b <= q.pop_front(); n--; end
   end
endmodule : bmf_fifo_dev_model
`default_nettype wire

// *** test/bmf_port_ctrl_assertions.sv ***
// Port-side and APB assertions for the FIFO port controller.
`timescale 1ns/1ns
`default_nettype none
module bmf_port_ctrl_assertions #(parameter int unsigned FIFO_DEPTH = 1024) (
   input wire logic       sys_clk_i, rst_n_i, psel_i, penable_i, pready_o, pslverr_o,
   input wire logic [7:0] paddr_i,
   input wire logic       port_a_clock_o, port_a_transfer_gate_o, port_a_direction_o, port_b_direction_o,
   input wire logic       port_a_data_oe_o, port_b_data_oe_o, port_b_mailbox_select_o, serial_program_select_n_o,
   input wire logic       master_reset_one_n_o, master_reset_two_n_o, offset_sel1_serial_load_gate_o
);
   localparam int SER = FIFO_DEPTH == 1024 ? 20 : FIFO_DEPTH == 512 ? 18 : 16;
   logic [5:0] rc_q, sc_q;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   // Port edges counted while reset or serial gate is low.
   always_ff @(posedge sys_clk_i) begin
      rc_q <= master_reset_one_n_o ? 6'h0 : rc_q + 6'($rose(port_a_clock_o));
      sc_q <= offset_sel1_serial_load_gate_o ? 6'h0 : sc_q + 6'($rose(port_a_clock_o));
   end
   // The span of 8 assumes the default half period of 4 cycles.
   sequence gate_open; $rose(port_a_transfer_gate_o); endsequence
   sequence gate_span; port_a_transfer_gate_o [*8] ##1 !port_a_transfer_gate_o; endsequence
   a_gate_one_period: assert property (gate_open |-> gate_span) else $error("gate width");
   a_gate_stable_rise: assert property ($rose(port_a_clock_o) |->
      $stable(port_a_transfer_gate_o) && $stable(port_a_direction_o)) else $error("pins move at rise");
   a_a_drive_write: assert property (port_a_data_oe_o |-> port_a_direction_o) else $error("A drive");
   a_b_drive_write: assert property (port_b_data_oe_o |->
      !port_b_direction_o && port_b_mailbox_select_o) else $error("B drive");
   a_reset_hold_four: assert property ($rose(master_reset_one_n_o) |-> rc_q >= 6'd4) else $error("short reset");
   a_reset_both_low: assert property ($fell(master_reset_one_n_o) |-> !master_reset_two_n_o) else $error("rst2");
   a_serial_bit_count: assert property ($rose(offset_sel1_serial_load_gate_o) && sc_q > 6'd5 |->
      sc_q == SER) else $error("serial count");
   a_serial_mode_only: assert property (!offset_sel1_serial_load_gate_o && master_reset_one_n_o &&
      $past(master_reset_one_n_o, 12) |-> !serial_program_select_n_o) else $error("serial gate");
   a_apb_answer: assert property (psel_i && penable_i |-> pready_o &&
      pslverr_o == (paddr_i > 8'h1c || paddr_i[1:0] != 2'h0)) else $error("apb answer");
endmodule : bmf_port_ctrl_assertions
bind bmf_port_ctrl bmf_port_ctrl_assertions #(.FIFO_DEPTH(FIFO_DEPTH)) chk_u (.*);
`default_nettype wire

// *** test/bmf_port_ctrl_tb_top.sv ***
// Self-checking bench: APB stimulus, device model and queue reference.
`timescale 1ns/1ns
`default_nettype none
module bmf_port_ctrl_tb_top;
   logic sys_clk_i = 0, rst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, er;
   logic [7:0] paddr_i = 0;
   logic [31:0] pwdata_i = 0, prdata_o, rd;
   logic pready_o, pslverr_o, port_a_clock_o, port_b_clock_o, port_a_transfer_gate_o, port_b_transfer_gate_o,
      port_a_direction_o, port_b_direction_o, port_a_mailbox_select_o, port_b_mailbox_select_o,
      master_reset_one_n_o, master_reset_two_n_o, partial_flush_reset_n_o, offset_sel1_serial_load_gate_o,
      offset_sel0_serial_bit_in_o, serial_program_select_n_o, endian_or_fall_through_select_o,
      read_bus_match_enable_o, port_b_byte_size_o, port_a_data_oe_o, port_b_data_oe_o,
      full_or_input_ready_flag_i, empty_or_output_ready_flag_i, mail_one_full_flag_n_i, mail_two_full_flag_n_i;
   logic [35:0] port_a_data_o, port_a_data_i, port_b_data_o, port_b_data_i, v, q[$];
   logic [19:0] offset_o;
   int num_errors = 0, check_count = 0;
   bmf_port_ctrl dut_u (.*);
   bmf_fifo_dev_model dev_u (.*);
   always #5 sys_clk_i = ~sys_clk_i;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k = 0;
      @(posedge sys_clk_i);
      psel_i <= 1'b1; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
      @(posedge sys_clk_i) penable_i <= 1'b1;
      do @(posedge sys_clk_i); while (pready_o !== 1'b1 && ++k < 50);
      if (k >= 50) num_errors++;
      rd = prdata_o; er = pslverr_o;
      psel_i <= 1'b0; penable_i <= 1'b0;
   endtask : apb
   task automatic chk(input string s, input logic [35:0] e, input logic [35:0] g);
      check_count++;
      if (e !== g) begin num_errors++; $display("wrong value %s expected %h seen %h", s, e, g); end
   endtask : chk
   // Waits until idle, then reads status once more.
   task automatic cmd(input logic [3:0] c);
      int k = 0;
      apb(1, 8'h04, {28'h0, c});
      do apb(0, 8'h1c, 0); while (rd[0] !== 1'b0 && ++k < 200);
      if (k >= 200) num_errors++;
      apb(0, 8'h1c, 0);
   endtask : cmd
   task automatic put(input logic [35:0] d);
      apb(1, 8'h08, d[31:0]); apb(1, 8'h0c, {28'h0, d[35:32]});
   endtask : put
   task automatic get();
      apb(0, 8'h10, 0); v[31:0] = rd; apb(0, 8'h14, 0); v[35:32] = rd[3:0];
   endtask : get
   task automatic close_out();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : close_out
   initial begin #300000; num_errors++; close_out(); end
   initial begin
      void'($urandom(47));
      repeat (5) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      apb(0, 8'h00, 0); chk("ctrl reset", 36'h4, 36'(rd));
      apb(0, 8'h1a, 0); chk("unaligned error", 36'h1, 36'(er));
      apb(1, 8'h00, 32'h2); cmd(4'h1);
      chk("timing pin", 36'h1, 36'(endian_or_fall_through_select_o));
      v = 36'($urandom); apb(1, 8'h18, v[31:0]);
      cmd(4'h7); chk("serial offset", 36'(v[19:0]), 36'(offset_o));
      for (int i = 0; i < 3; i++) begin v = 36'({$urandom, $urandom}); q.push_back(v); put(v); cmd(4'h3); end
      chk("read flag", 36'h1, 36'(rd[3]));
      chk("write flag", 36'h1, 36'(rd[2]));
      repeat (2) begin cmd(4'h6); get(); chk("fifo word", q.pop_front(), v); end
      cmd(4'h2); q.delete(); cmd(4'h6); chk("empty refused", 36'h1, 36'(rd[1]));
      v = 36'({$urandom, $urandom}); q.push_back(v); put(v);
      cmd(4'hb); chk("mail one flag", 36'h0, 36'(rd[4]));
      put(~v); cmd(4'hb); chk("mail one refused", 36'h1, 36'(rd[1]));
      cmd(4'he); chk("mail one freed", 36'h1, 36'(rd[4])); get(); chk("mail one data", q.pop_front(), v);
      v = 36'({$urandom, $urandom}); q.push_back(v); put(v);
      cmd(4'hd); chk("mail two flag", 36'h0, 36'(rd[5]));
      put(~v); cmd(4'hd); chk("mail two refused", 36'h1, 36'(rd[1]));
      cmd(4'hc); chk("mail two freed", 36'h1, 36'(rd[5])); get(); chk("mail two data", q.pop_front(), v);
      close_out();
   end
endmodule : bmf_port_ctrl_tb_top
`default_nettype wire

// *** verilog/bmf_params.svh ***
// Constants of the FIFO port controller.
`ifndef BMF_PARAMS_SVH
`define BMF_PARAMS_SVH

// Register byte offsets on the APB side.
`define BMF_OFF_CTRL      8'h00
`define BMF_OFF_CMD       8'h04
`define BMF_OFF_WDATA_LO  8'h08
`define BMF_OFF_WDATA_HI  8'h0c
`define BMF_OFF_RDATA_LO  8'h10
`define BMF_OFF_RDATA_HI  8'h14
`define BMF_OFF_SERIAL    8'h18
`define BMF_OFF_STATUS    8'h1c

// Control register fields.
`define BMF_CTRL_FS0      0
`define BMF_CTRL_FS1      1
`define BMF_CTRL_SPM_N    2
`define BMF_CTRL_BIG_END  3
`define BMF_CTRL_FWFT     4
`define BMF_CTRL_BM       5
`define BMF_CTRL_SIZE     6
`define BMF_CTRL_W        7
`define BMF_CTRL_RESET    7'h04

// Command register fields.
`define BMF_CMD_OP_LSB    0
`define BMF_CMD_OP_MSB    2
`define BMF_CMD_MBX       3

// Status register fields.
`define BMF_ST_BUSY       0
`define BMF_ST_REFUSED    1
`define BMF_ST_SPACE      2
`define BMF_ST_DATA       3
`define BMF_ST_MAIL1_N    4
`define BMF_ST_MAIL2_N    5

// Device geometry and timing.
`define BMF_DATA_W        36
`define BMF_DEPTH_DEFAULT 1024
`define BMF_SER_BITS_256  16
`define BMF_SER_BITS_512  18
`define BMF_SER_BITS_1024 20
`define BMF_RESET_EDGES   4
`define BMF_SYS_PERIOD_NS 10
`define BMF_PORT_HALF_NS  40
`define BMF_CLK_HALF_CYC  (`BMF_PORT_HALF_NS / `BMF_SYS_PERIOD_NS)
`define BMF_SYNC_W        76

`endif

// *** verilog/bmf_pin_sync.sv ***
// Three-stage synchroniser for device pins with an agreement filter.
`timescale 1ns/1ns
`default_nettype none

module bmf_pin_sync
   import bmf_pkg::*;
(
   input  wire logic sys_clk_i,
   input  wire logic rst_n_i,
   bmf_sync_if.sync  sif
);
   localparam int unsigned W = $bits(sif.raw);

   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   logic [W-1:0] clean_q;

   // Only stages two and three feed the filter.
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         s1_q    <= '0;
         s2_q    <= '0;
         s3_q    <= '0;
         clean_q <= '0;
      end else begin
         s1_q    <= sif.raw;
         s2_q    <= s1_q;
         s3_q    <= s2_q;
         clean_q <= (s2_q & s3_q) | (clean_q & (s2_q ^ s3_q));
      end
   end

   assign sif.clean = clean_q;

endmodule : bmf_pin_sync

`default_nettype wire

// *** verilog/bmf_pkg.sv ***
// Types shared by the port controller.
`include "bmf_params.svh"

package bmf_pkg;

   typedef enum logic [2:0] {
      OP_NONE = 3'h0,
      OP_MRST = 3'h1,
      OP_PRST = 3'h2,
      OP_AWR  = 3'h3,
      OP_ARD  = 3'h4,
      OP_BWR  = 3'h5,
      OP_BRD  = 3'h6,
      OP_SER  = 3'h7
   } bmf_op_e;

   typedef enum logic [2:0] {
      ST_IDLE    = 3'h0,
      ST_RESET   = 3'h1,
      ST_RELEASE = 3'h2,
      ST_XFER    = 3'h3,
      ST_WAIT    = 3'h4,
      ST_SERIAL  = 3'h5
   } bmf_state_e;

   function automatic int unsigned bmf_serial_bits(input int unsigned depth);
      if (depth == 1024) begin
         return `BMF_SER_BITS_1024;
      end
      if (depth == 512) begin
         return `BMF_SER_BITS_512;
      end
      return `BMF_SER_BITS_256;
   endfunction : bmf_serial_bits

endpackage : bmf_pkg

// *** verilog/bmf_port_ctrl.sv ***
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/1ns
`default_nettype none

module bmf_port_ctrl
   import bmf_pkg::*;
#(
   parameter int unsigned FIFO_DEPTH = `BMF_DEPTH_DEFAULT,
   parameter int unsigned CLK_HALF   = `BMF_CLK_HALF_CYC
)
(
   input  wire logic        sys_clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output var  logic [31:0] prdata_o,
   output var  logic        pready_o,
   output var  logic        pslverr_o,
   output var  logic        port_a_clock_o,
   output var  logic        port_b_clock_o,
   output var  logic        port_a_transfer_gate_o,
   output var  logic        port_b_transfer_gate_o,
   output var  logic        port_a_direction_o,
   output var  logic        port_b_direction_o,
   output var  logic        port_a_mailbox_select_o,
   output var  logic        port_b_mailbox_select_o,
   output var  logic        master_reset_one_n_o,
   output var  logic        master_reset_two_n_o,
   output var  logic        partial_flush_reset_n_o,
   output var  logic        offset_sel1_serial_load_gate_o,
   output var  logic        offset_sel0_serial_bit_in_o,
   output var  logic        serial_program_select_n_o,
   output var  logic        endian_or_fall_through_select_o,
   output var  logic        read_bus_match_enable_o,
   output var  logic        port_b_byte_size_o,
   output var  logic [35:0] port_a_data_o,
   output var  logic        port_a_data_oe_o,
   input  wire logic [35:0] port_a_data_i,
   output var  logic [35:0] port_b_data_o,
   output var  logic        port_b_data_oe_o,
   input  wire logic [35:0] port_b_data_i,
   input  wire logic        full_or_input_ready_flag_i,
   input  wire logic        empty_or_output_ready_flag_i,
   input  wire logic        mail_one_full_flag_n_i,
   input  wire logic        mail_two_full_flag_n_i
);

   localparam int unsigned SER_BITS = bmf_serial_bits(FIFO_DEPTH);
   localparam logic [7:0]  HALF_M1  = 8'(CLK_HALF - 1);
   localparam logic [4:0]  SER_LAST = 5'(SER_BITS - 1);
   localparam logic [4:0]  RST_LAST = 5'(`BMF_RESET_EDGES - 1);

   // Reads need a half period of at least four cycles for the synchroniser to settle.
   if (CLK_HALF < 4 || CLK_HALF > 256) begin : g_bad_half
      $error("CLK_HALF must lie between 4 and 256");
   end
   if (FIFO_DEPTH != 256 && FIFO_DEPTH != 512 && FIFO_DEPTH != 1024) begin : g_bad_depth
      $error("FIFO_DEPTH must be 256, 512 or 1024");
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Port clock divider; both port clocks are coincident.

   logic [7:0] div_q;
   logic       clk_q;
   logic       fall_evt;

   assign fall_evt = (div_q == HALF_M1) && clk_q;

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         div_q <= 8'h00;
         clk_q <= 1'b0;
      end else if (div_q == HALF_M1) begin
         div_q <= 8'h00;
         clk_q <= ~clk_q;
      end else begin
         div_q <= div_q + 8'h01;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         port_a_clock_o <= 1'b0;
         port_b_clock_o <= 1'b0;
      end else begin
         port_a_clock_o <= clk_q;
         port_b_clock_o <= clk_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisation.

   bmf_sync_if #(.W(`BMF_SYNC_W)) sif ();

   assign sif.raw = {mail_two_full_flag_n_i, mail_one_full_flag_n_i, empty_or_output_ready_flag_i,
                     full_or_input_ready_flag_i, port_b_data_i, port_a_data_i};

   bmf_pin_sync u_sync (
      .sys_clk_i (sys_clk_i),
      .rst_n_i   (rst_n_i),
      .sif       (sif)
   );

   logic [35:0] a_data_s;
   logic [35:0] b_data_s;
   logic        space_s;
   logic        data_s;
   logic        mail1_n_s;
   logic        mail2_n_s;

   assign {mail2_n_s, mail1_n_s, data_s, space_s, b_data_s, a_data_s} = sif.clean;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // APB slave with zero wait states; read data and error are prepared in the setup cycle.

   logic [`BMF_CTRL_W-1:0] ctrl_q;
   logic [35:0]            wdata_q;
   logic [35:0]            rdata_q;
   logic [SER_BITS-1:0]    ser_q;
   logic                   refused_q;
   logic                   pend_q;
   bmf_state_e             state_q;
   logic                   apb_wr;
   logic                   cmd_wr;
   logic                   busy;

   assign apb_wr = psel_i && penable_i && pwrite_i;
   assign cmd_wr = apb_wr && (paddr_i == `BMF_OFF_CMD);
   assign busy   = pend_q || (state_q != ST_IDLE);

   function automatic logic addr_ok(input logic [7:0] a);
      return a[1:0] == 2'b00 && a <= `BMF_OFF_STATUS;
   endfunction : addr_ok

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         ctrl_q    <= `BMF_CTRL_RESET;
         wdata_q   <= '0;
         ser_q     <= '0;
         prdata_o  <= 32'h0000_0000;
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
      end else begin
         pready_o <= 1'b1;
         if (psel_i && !penable_i) begin
            pslverr_o <= !addr_ok(paddr_i);
            prdata_o  <= 32'h0000_0000;
            if (!pwrite_i) begin
               unique case (paddr_i)
                  `BMF_OFF_CTRL:     prdata_o <= 32'(ctrl_q);
                  `BMF_OFF_WDATA_LO: prdata_o <= wdata_q[31:0];
                  `BMF_OFF_WDATA_HI: prdata_o <= 32'(wdata_q[35:32]);
                  `BMF_OFF_RDATA_LO: prdata_o <= rdata_q[31:0];
                  `BMF_OFF_RDATA_HI: prdata_o <= 32'(rdata_q[35:32]);
                  `BMF_OFF_SERIAL:   prdata_o <= 32'(ser_q);
                  `BMF_OFF_STATUS:   prdata_o <= 32'({mail2_n_s, mail1_n_s, data_s, space_s, refused_q, busy});
                  default:           prdata_o <= 32'h0000_0000;
               endcase
            end
         end
         if (apb_wr) begin
            unique case (paddr_i)
               `BMF_OFF_CTRL:     ctrl_q           <= pwdata_i[`BMF_CTRL_W-1:0];
               `BMF_OFF_WDATA_LO: wdata_q[31:0]    <= pwdata_i;
               `BMF_OFF_WDATA_HI: wdata_q[35:32]   <= pwdata_i[3:0];
               `BMF_OFF_SERIAL:   ser_q            <= pwdata_i[SER_BITS-1:0];
               default: ;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Operation sequencer. Pins change only when the port clock falls, so they are stable at its rise.

   bmf_op_e             op_q;
   logic                mbx_q;
   logic [4:0]          cnt_q;
   logic [SER_BITS-1:0] sh_q;

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         state_q <= ST_IDLE;
         op_q <= OP_NONE;
         mbx_q <= 1'b0;
         pend_q <= 1'b0;
         refused_q <= 1'b0;
         cnt_q <= 5'h00;
         sh_q <= '0;
         rdata_q <= '0;
         port_a_transfer_gate_o <= 1'b0;
         port_b_transfer_gate_o <= 1'b0;
         port_a_direction_o <= 1'b1;
         port_b_direction_o <= 1'b0;
         port_a_mailbox_select_o <= 1'b0;
         port_b_mailbox_select_o <= 1'b0;
         master_reset_one_n_o <= 1'b1;
         master_reset_two_n_o <= 1'b1;
         partial_flush_reset_n_o <= 1'b1;
         offset_sel1_serial_load_gate_o <= 1'b1;
         offset_sel0_serial_bit_in_o <= 1'b0;
         serial_program_select_n_o <= 1'b1;
         endian_or_fall_through_select_o <= 1'b1;
         read_bus_match_enable_o <= 1'b0;
         port_b_byte_size_o <= 1'b0;
         port_a_data_o <= '0;
         port_a_data_oe_o <= 1'b0;
         port_b_data_o <= '0;
         port_b_data_oe_o <= 1'b0;
      end else begin
         // A command written while busy is dropped and reported.
         if (cmd_wr) begin
            if (busy) begin
               refused_q <= 1'b1;
            end else begin
               pend_q    <= 1'b1;
               op_q      <= bmf_op_e'(pwdata_i[`BMF_CMD_OP_MSB:`BMF_CMD_OP_LSB]);
               mbx_q     <= pwdata_i[`BMF_CMD_MBX];
               refused_q <= 1'b0;
            end
         end
         if (fall_evt) begin
            unique case (state_q)
               ST_IDLE: begin
                  if (pend_q) begin
                     pend_q <= 1'b0;
                     unique case (op_q)
                        OP_MRST: begin
                           master_reset_one_n_o            <= 1'b0;
                           master_reset_two_n_o            <= 1'b0;
                           offset_sel1_serial_load_gate_o  <= ctrl_q[`BMF_CTRL_FS1];
                           offset_sel0_serial_bit_in_o     <= ctrl_q[`BMF_CTRL_FS0];
                           serial_program_select_n_o       <= ctrl_q[`BMF_CTRL_SPM_N];
                           endian_or_fall_through_select_o <= ctrl_q[`BMF_CTRL_BIG_END];
                           read_bus_match_enable_o         <= ctrl_q[`BMF_CTRL_BM];
                           port_b_byte_size_o              <= ctrl_q[`BMF_CTRL_SIZE];
                           cnt_q                           <= 5'h00;
                           state_q                         <= ST_RESET;
                        end
                        OP_PRST: begin
                           partial_flush_reset_n_o <= 1'b0;
                           cnt_q                   <= 5'h00;
                           state_q                 <= ST_RESET;
                        end
                        OP_AWR: begin
                           if (mbx_q ? !mail1_n_s : !space_s) begin
                              refused_q <= 1'b1;
                           end else begin
                              port_a_direction_o      <= 1'b1;
                              port_a_mailbox_select_o <= mbx_q;
                              port_a_transfer_gate_o  <= 1'b1;
                              port_a_data_o           <= wdata_q;
                              port_a_data_oe_o        <= 1'b1;
                              state_q                 <= ST_XFER;
                           end
                        end
                        OP_ARD: begin
                           // Read mail two only when present.
                           if (!mbx_q || mail2_n_s) begin
                              refused_q <= 1'b1;
                           end else begin
                              port_a_direction_o      <= 1'b0;
                              port_a_mailbox_select_o <= 1'b1;
                              port_a_transfer_gate_o  <= 1'b1;
                              state_q                 <= ST_XFER;
                           end
                        end
                        OP_BWR: begin
                           if (!mbx_q || !mail2_n_s) begin
                              refused_q <= 1'b1;
                           end else begin
                              port_b_direction_o      <= 1'b0;
                              port_b_mailbox_select_o <= 1'b1;
                              port_b_transfer_gate_o  <= 1'b1;
                              port_b_data_o           <= wdata_q;
                              port_b_data_oe_o        <= 1'b1;
                              state_q                 <= ST_XFER;
                           end
                        end
                        OP_BRD: begin
                           if (mbx_q ? mail1_n_s : !data_s) begin
                              refused_q <= 1'b1;
                           end else begin
                              port_b_direction_o      <= 1'b1;
                              port_b_mailbox_select_o <= mbx_q;
                              port_b_transfer_gate_o  <= 1'b1;
                              state_q                 <= ST_XFER;
                           end
                        end
                        OP_SER: begin
                           if (serial_program_select_n_o) begin
                              refused_q <= 1'b1;
                           end else begin
                              offset_sel0_serial_bit_in_o    <= ser_q[SER_BITS-1];
                              offset_sel1_serial_load_gate_o <= 1'b0;
                              sh_q                           <= ser_q;
                              cnt_q                          <= 5'h00;
                              state_q                        <= ST_SERIAL;
                           end
                        end
                        default: ;
                     endcase
                  end
               end
               ST_RESET: begin
                  if (cnt_q == RST_LAST) begin
                     master_reset_one_n_o    <= 1'b1;
                     master_reset_two_n_o    <= 1'b1;
                     partial_flush_reset_n_o <= 1'b1;
                     state_q                 <= ST_RELEASE;
                  end else begin
                     cnt_q <= cnt_q + 5'h01;
                  end
               end
               ST_RELEASE: begin
                  endian_or_fall_through_select_o <= !ctrl_q[`BMF_CTRL_FWFT];
                  offset_sel1_serial_load_gate_o  <= 1'b1;
                  offset_sel0_serial_bit_in_o     <= 1'b0;
                  state_q                         <= ST_IDLE;
               end
               ST_XFER: begin
                  port_a_transfer_gate_o <= 1'b0;
                  port_b_transfer_gate_o <= 1'b0;
                  port_a_data_oe_o       <= 1'b0;
                  port_b_data_oe_o       <= 1'b0;
                  if (op_q == OP_ARD || op_q == OP_BRD) begin
                     state_q <= ST_WAIT;
                  end else begin
                     port_a_mailbox_select_o <= 1'b0;
                     port_b_mailbox_select_o <= 1'b0;
                     state_q                 <= ST_IDLE;
                  end
               end
               ST_WAIT: begin
                  // The device output has been stable for a full port period here.
                  rdata_q                 <= (op_q == OP_ARD) ? a_data_s : b_data_s;
                  port_a_direction_o      <= 1'b1;
                  port_b_direction_o      <= 1'b0;
                  port_a_mailbox_select_o <= 1'b0;
                  port_b_mailbox_select_o <= 1'b0;
                  state_q                 <= ST_IDLE;
               end
               ST_SERIAL: begin
                  // Stop after the variant's bit count.
                  if (cnt_q == SER_LAST) begin
                     offset_sel1_serial_load_gate_o <= 1'b1;
                     offset_sel0_serial_bit_in_o    <= 1'b0;
                     state_q                        <= ST_IDLE;
                  end else begin
                     cnt_q                       <= cnt_q + 5'h01;
                     sh_q                        <= sh_q << 1;
                     offset_sel0_serial_bit_in_o <= sh_q[SER_BITS-2];
                  end
               end
               default: state_q <= ST_IDLE;
            endcase
         end
      end
   end

endmodule : bmf_port_ctrl

`default_nettype wire

// *** verilog/bmf_sync_if.sv ***
// Carrier between the pin synchroniser and the controller.
`timescale 1ns/1ns
`default_nettype none

interface bmf_sync_if #(parameter int unsigned W = 76);
   logic [W-1:0] raw;
   logic [W-1:0] clean;
   modport sync (input raw, output clean);
   modport user (output raw, input clean);
endinterface : bmf_sync_if

`default_nettype wire
